// [verification/charger_ctrl_irq_regs_test.sv]
`timescale 1ns/100ps
module charger_ctrl_irq_regs_test;
  logic clk = 1'b0, rst = 1'b1, interrupt_mask = 1'b1;
  logic off_state = 1'b0, reg_reset_cmd = 1'b0, boost_mode_entry = 1'b0;
  logic temp_warning_cmp = 1'b0, temp_level_one_cmp = 1'b0;
  logic temp_level_two_cmp = 1'b0, thermal_shutdown_cmp = 1'b0;
  logic bus_undervoltage_cmp = 1'b1, bus_overvoltage_cmp = 1'b0;
  logic charger_detect_cmp = 1'b0, input_detect_cmp = 1'b0;
  logic input_overvoltage_cmp = 1'b0, battery_overvoltage_cmp = 1'b0;
  logic timer_fault_pending = 1'b0, boost_fault_pending = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q, opt;
  logic reg_wr, reg_rd, thermal_summary, fault_summary, interrupt_active;
  logic watchdog_disable, charge_timer_disable, power_path_enable;
  logic transceiver_supply, limit_source_pins, input_limit_enable;
  logic auto_charge_current_enable;
  int fails = 0, n_compared = 0;
  charger_ctrl_irq_regs dut (.*);
  host_model host (.*);
  assign opt = {watchdog_disable, charge_timer_disable, power_path_enable,
    transceiver_supply, 1'b0, limit_source_pins, input_limit_enable,
    auto_charge_current_enable};
  always #4 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, q);
    check(q, exp);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic settemp(input logic [3:0] v);
    @(negedge clk);
    {temp_warning_cmp, temp_level_one_cmp, temp_level_two_cmp,
      thermal_shutdown_cmp} = v;
  endtask
  task automatic setf(input logic [5:0] v);
    @(negedge clk);
    {charger_detect_cmp, input_detect_cmp, input_overvoltage_cmp,
      battery_overvoltage_cmp, timer_fault_pending, bus_undervoltage_cmp} = v;
  endtask
  task automatic t_regs;
    rchk(8'h02, 8'h16);
    rchk(8'h07, 8'h00);
    host.wr(8'h02, 8'hff);
    check(opt, 8'hf7);
    rchk(8'h02, 8'hf7);
    host.wr(8'h03, 8'hff);
    rchk(8'h03, 8'h00);
    host.wr(8'h02, 8'h00);
    pulse(boost_mode_entry);
    rchk(8'h02, 8'h06);
    pulse(reg_reset_cmd);
    rchk(8'h02, 8'h16);
    $display("registers test done");
  endtask
  task automatic t_temp;
    settemp(4'hf);
    settemp(4'h1);
    rchk(8'h03, 8'h3c);
    rchk(8'h03, 8'h04);
    settemp(4'h0);
    check({7'h00, interrupt_active}, 8'h00);
    interrupt_mask = 1'b0;
    #1 check({7'h00, interrupt_active}, 8'h01);
    interrupt_mask = 1'b1;
    settemp(4'h8);
    settemp(4'h0);
    pulse(boost_mode_entry);
    rchk(8'h03, 8'h24);
    settemp(4'h8);
    settemp(4'h0);
    pulse(off_state);
    rchk(8'h03, 8'h00);
    $display("thermal test done");
  endtask
  task automatic t_fault;
    setf(6'b101110);
    setf(6'b000011);
    rchk(8'h04, 8'h1b);
    rchk(8'h03, 8'h01);
    check({7'h00, fault_summary}, 8'h01);
    rchk(8'h04, 8'h01);
    setf(6'b110011);
    setf(6'b000011);
    rchk(8'h04, 8'h01);
    setf(6'b101110);
    setf(6'b000011);
    pulse(boost_mode_entry);
    rchk(8'h04, 8'h01);
    rchk(8'h03, 8'h00);
    $display("fault test done");
  endtask
  task automatic t_summary;
    @(negedge clk);
    timer_fault_pending = 1'b0;
    bus_undervoltage_cmp = 1'b0;
    bus_overvoltage_cmp = 1'b1;
    rchk(8'h03, 8'h00);
    #1 check({7'h00, fault_summary}, 8'h00);
    check({7'h00, thermal_summary}, 8'h00);
    @(negedge clk);
    boost_fault_pending = 1'b1;
    #1 check({7'h00, fault_summary}, 8'h01);
    @(negedge clk);
    boost_fault_pending = 1'b0;
    bus_overvoltage_cmp = 1'b0;
    rchk(8'h03, 8'h01);
    #1 check({7'h00, thermal_summary}, 8'h01);
    $display("summary test done");
  endtask
  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_regs;
    t_temp;
    t_fault;
    t_summary;
    stop_test;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    stop_test;
  end
endmodule

// [verification/charger_regs_assertions.sv]
`timescale 1ns/100ps
module charger_regs_assertions (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Events and levels.
  input wire logic off_state,
  input wire logic reg_reset_cmd,
  input wire logic boost_mode_entry,
  input wire logic thermal_shutdown_cmp,
  input wire logic timer_fault_pending,
  input wire logic interrupt_mask,
  // Option controls.
  input wire logic watchdog_disable,
  input wire logic charge_timer_disable,
  input wire logic power_path_enable,
  input wire logic transceiver_supply,
  input wire logic limit_source_pins,
  input wire logic input_limit_enable,
  input wire logic auto_charge_current_enable,
  // Summaries and interrupt.
  input wire logic thermal_summary,
  input wire logic fault_summary,
  input wire logic interrupt_active
);
  logic [7:0] opt;
  logic ev;
  assign opt = {watchdog_disable, charge_timer_disable, power_path_enable,
    transceiver_supply, 1'b0, limit_source_pins, input_limit_enable,
    auto_charge_current_enable};
  assign ev = off_state | reg_reset_cmd;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_option_write: assert property (
    reg_wr && reg_addr == 8'h02 && !ev && !boost_mode_entry
    |=> opt == ($past(reg_wdata) & 8'hf7)) else $error("write lost");
  a_reset_event: assert property (ev |=> opt == 8'h16)
    else $error("option not reset");
  a_boost_keep: assert property (
    boost_mode_entry && !ev && !reg_wr
    |=> opt == (8'h06 | ($past(opt) & 8'h10))) else $error("boost reset");
  a_read_option: assert property (
    reg_rd && reg_addr == 8'h02 |=> reg_rdata == $past(opt))
    else $error("option read wrong");
  a_read_unmapped: assert property (
    reg_rd && (reg_addr < 8'h02 || reg_addr > 8'h04) |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_temp_latch: assert property (
    thermal_shutdown_cmp && !ev |=> thermal_summary) else $error("no latch");
  a_timer_summary: assert property (
    timer_fault_pending |-> fault_summary) else $error("no fault summary");
  a_intr_gate: assert property (
    interrupt_active == ((thermal_summary || fault_summary) &&
    !interrupt_mask)) else $error("interrupt gating");
endmodule

bind charger_ctrl_irq_regs charger_regs_assertions chk (.*);

// [verification/host_model.sv]
`timescale 1ns/100ps
module host_model (
  // Clock and read data.
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  // Register requests.
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // Each read pulse is one read, so it clears latched flags whose condition has gone.
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    q = reg_rdata;
  endtask
endmodule

// [verilog/charger_ctrl_irq_regs.sv]
`timescale 1ns/100ps
// Functional notes
// R1: Option bit 7 set disables the watchdog timer; default 0.
// R2: Option bit 6 set disables the charge safety timer; default 0.
// R3: Option bit 5 set enables power path management; default 0.
// R4: Option bit 4 set supplies the transceiver pin; default 1.
// R5: Option bit 2 picks limit-select pins (1) or registers (0); default 1.
// R6: Option bit 1 set applies the 4-bit input limit field; default 1.
// R7: Option bit 0 set enables automatic charge current; default 0.
// R8: Option bits reset on all events; bit 4 survives boost-mode entry.
// R9: Thermal bit 5 flags die temperature above the warning threshold.
// R10: Thermal bit 4 flags die temperature above the first threshold.
// R11: Thermal bit 3 flags die temperature above the second threshold.
// R12: Thermal bit 2 flags die temperature above thermal shutdown.
// R13: Temperature flags clear on reset events but not on boost entry.
// R14: Thermal bit 0 shows input voltage inside the bus charging range.
// R15: Fault bit 4 flags input above charger margin but below detect level.
// R16: Fault bit 3 flags input overvoltage lockout.
// R17: Fault bit 1 flags battery overvoltage.
// R18: In-range bit and input fault flags also clear on boost entry.
// R19: Fault bit 0 is read-only summary of the timer fault register.
// R20: Thermal summary output shows any thermal flag pending.
// R21: Fault summary shows any input, timer or boost flag pending.
// R22: Global mask set keeps the interrupt inactive; clear allows it.
// R23: A read clears latched flags unless the condition still holds.
// R24: Reserved bits read zero and ignore writes.
module charger_ctrl_irq_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port from the control bus slave.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Reset events.
  input wire logic off_state,
  input wire logic reg_reset_cmd,
  input wire logic boost_mode_entry,
  // Comparator levels.
  input wire logic temp_warning_cmp,
  input wire logic temp_level_one_cmp,
  input wire logic temp_level_two_cmp,
  input wire logic thermal_shutdown_cmp,
  input wire logic bus_undervoltage_cmp,
  input wire logic bus_overvoltage_cmp,
  input wire logic charger_detect_cmp,
  input wire logic input_detect_cmp,
  input wire logic input_overvoltage_cmp,
  input wire logic battery_overvoltage_cmp,
  // Summaries from neighbouring flag registers and the global mask.
  input wire logic timer_fault_pending,
  input wire logic boost_fault_pending,
  input wire logic interrupt_mask,
  // Option controls.
  output logic watchdog_disable,
  output logic charge_timer_disable,
  output logic power_path_enable,
  output logic transceiver_supply,
  output logic limit_source_pins,
  output logic input_limit_enable,
  output logic auto_charge_current_enable,
  // Summaries and interrupt.
  output logic thermal_summary,
  output logic fault_summary,
  output logic interrupt_active
);

  // Everything that holds state lives in one packed struct.
  typedef struct packed {
    logic [7:0] option;
    logic [3:0] temp_flags;
    logic in_range;
    logic input_low;
    logic input_ov;
    logic battery_ov;
    logic [7:0] rdata;
  } state_s;

  state_s state;
  state_s next_state;

  // Address decode.
  logic hit_option;
  logic hit_thermal;
  logic hit_fault;
  logic write_option;
  logic read_thermal;
  logic read_fault;

  // Reset events.
  logic full_clear;
  logic boost_clear;

  // Live conditions.
  logic [3:0] temp_cond;
  logic in_range_cond;
  logic input_low_cond;
  logic input_ov_cond;
  logic battery_ov_cond;

  // Flag values after latching and read-clear.
  logic [3:0] temp_latched;
  logic in_range_latched;
  logic input_low_latched;
  logic input_ov_latched;
  logic battery_ov_latched;

  // Next values per field.
  logic [7:0] option_written;
  logic [7:0] option_after_boost;
  logic [7:0] next_option;
  logic [3:0] next_temp_flags;
  logic next_in_range;
  logic next_input_low;
  logic next_input_ov;
  logic next_battery_ov;
  logic [7:0] next_rdata;

  // Read views and summaries.
  logic [7:0] option_view;
  logic [7:0] thermal_view;
  logic [7:0] fault_view;
  logic thermal_any;
  logic fault_any;

  // A write and a read may share a cycle; each acts on its own strobe.
  assign hit_option = reg_addr == charger_regs_pkg::OPTION_ADDR;
  assign hit_thermal = reg_addr == charger_regs_pkg::THERMAL_ADDR;
  assign hit_fault = reg_addr == charger_regs_pkg::FAULT_ADDR;
  assign write_option = reg_wr & hit_option;
  assign read_thermal = reg_rd & hit_thermal;
  assign read_fault = reg_rd & hit_fault;

  // Power-on reset, off state and register-reset command load the option reset value and clear all flags.
  assign full_clear = rst | off_state | reg_reset_cmd; // [R8] [R13] [R18]
  // Boost entry matters only when no full clear comes with it.
  // A full clear already covers everything that boost entry resets.
  assign boost_clear = boost_mode_entry & ~full_clear; // [R8] [R18]

  // Comparator levels, high while the condition holds.
  assign temp_cond[3] = temp_warning_cmp; // [R9]
  assign temp_cond[2] = temp_level_one_cmp; // [R10]
  assign temp_cond[1] = temp_level_two_cmp; // [R11]
  assign temp_cond[0] = thermal_shutdown_cmp; // [R12]
  assign in_range_cond =
    ~bus_undervoltage_cmp & ~bus_overvoltage_cmp; // [R14]
  assign input_low_cond = charger_detect_cmp & ~input_detect_cmp; // [R15]
  assign input_ov_cond = input_overvoltage_cmp; // [R16]
  assign battery_ov_cond = battery_overvoltage_cmp; // [R17]

  // A live condition sets its flag; a read clears the flag only once
  // the condition has gone, so the set wins over the clear.
  for (genvar i = 0; i < 4; i++) begin : g_temp
    assign temp_latched[i] =
      temp_cond[i] | (state.temp_flags[i] & ~read_thermal); // [R23]
  end
  assign in_range_latched =
    in_range_cond | (state.in_range & ~read_thermal); // [R23]
  assign input_low_latched =
    input_low_cond | (state.input_low & ~read_fault); // [R23]
  assign input_ov_latched =
    input_ov_cond | (state.input_ov & ~read_fault); // [R23]
  assign battery_ov_latched =
    battery_ov_cond | (state.battery_ov & ~read_fault); // [R23]

  // Option register; reserved bit 3 stays zero whatever is written.
  always_comb begin
    option_written = reg_wdata & charger_regs_pkg::OPTION_WRITABLE; // [R24]
    option_after_boost =
      (state.option & charger_regs_pkg::OPTION_KEEP_ON_BOOST) |
      (charger_regs_pkg::OPTION_RESET &
       ~charger_regs_pkg::OPTION_KEEP_ON_BOOST); // [R8]
    // A full clear outranks boost entry, which outranks a host write.
    if (full_clear) begin
      next_option = charger_regs_pkg::OPTION_RESET; // [R8]
    end else if (boost_clear) begin
      next_option = option_after_boost; // [R8]
    end else if (write_option) begin
      next_option = option_written;
    end else begin
      next_option = state.option;
    end
  end

  // Boost entry leaves the temperature flags alone.
  always_comb begin
    if (full_clear) begin
      next_temp_flags = charger_regs_pkg::TEMP_FLAGS_RESET; // [R13]
    end else begin
      next_temp_flags = temp_latched; // [R13]
    end
  end

  // Boost entry clears the in-range bit and the input fault flags, even
  // while their conditions hold; they set again on the next cycle.
  always_comb begin
    if (full_clear || boost_clear) begin
      next_in_range = charger_regs_pkg::FLAG_RESET; // [R18]
    end else begin
      next_in_range = in_range_latched; // [R14]
    end
  end

  always_comb begin
    if (full_clear || boost_clear) begin
      next_input_low = charger_regs_pkg::FLAG_RESET; // [R18]
    end else begin
      next_input_low = input_low_latched; // [R15]
    end
  end

  always_comb begin
    if (full_clear || boost_clear) begin
      next_input_ov = charger_regs_pkg::FLAG_RESET; // [R18]
    end else begin
      next_input_ov = input_ov_latched; // [R16]
    end
  end

  always_comb begin
    if (full_clear || boost_clear) begin
      next_battery_ov = charger_regs_pkg::FLAG_RESET; // [R18]
    end else begin
      next_battery_ov = battery_ov_latched; // [R17]
    end
  end

  // Read data is taken from the flags before the same read clears them.
  always_comb begin
    if (rst) begin
      next_rdata = charger_regs_pkg::UNMAPPED_DATA;
    end else if (!reg_rd) begin
      next_rdata = state.rdata;
    end else if (hit_option) begin
      next_rdata = option_view;
    end else if (hit_thermal) begin
      next_rdata = thermal_view;
    end else if (hit_fault) begin
      next_rdata = fault_view;
    end else begin
      next_rdata = charger_regs_pkg::UNMAPPED_DATA; // [R24]
    end
  end

  // The option view rebuilds the register bit by bit, so bit 3 reads 0.
  always_comb begin
    option_view = 8'h00; // [R24]
    option_view[charger_regs_pkg::WATCHDOG_DISABLE_BIT] =
      state.option[charger_regs_pkg::WATCHDOG_DISABLE_BIT];
    option_view[charger_regs_pkg::CHARGE_TIMER_DISABLE_BIT] =
      state.option[charger_regs_pkg::CHARGE_TIMER_DISABLE_BIT];
    option_view[charger_regs_pkg::POWER_PATH_ENABLE_BIT] =
      state.option[charger_regs_pkg::POWER_PATH_ENABLE_BIT];
    option_view[charger_regs_pkg::TRANSCEIVER_SUPPLY_BIT] =
      state.option[charger_regs_pkg::TRANSCEIVER_SUPPLY_BIT];
    option_view[charger_regs_pkg::LIMIT_SOURCE_PINS_BIT] =
      state.option[charger_regs_pkg::LIMIT_SOURCE_PINS_BIT];
    option_view[charger_regs_pkg::INPUT_LIMIT_ENABLE_BIT] =
      state.option[charger_regs_pkg::INPUT_LIMIT_ENABLE_BIT];
    option_view[charger_regs_pkg::AUTO_CHARGE_CURRENT_ENABLE_BIT] =
      state.option[charger_regs_pkg::AUTO_CHARGE_CURRENT_ENABLE_BIT];
  end

  // Flag views; reserved bits read zero.
  always_comb begin
    thermal_view = 8'h00; // [R24]
    thermal_view[charger_regs_pkg::TEMP_WARNING_BIT] =
      state.temp_flags[3]; // [R9]
    thermal_view[charger_regs_pkg::TEMP_LEVEL_ONE_BIT] =
      state.temp_flags[2]; // [R10]
    thermal_view[charger_regs_pkg::TEMP_LEVEL_TWO_BIT] =
      state.temp_flags[1]; // [R11]
    thermal_view[charger_regs_pkg::THERMAL_SHUTDOWN_BIT] =
      state.temp_flags[0]; // [R12]
    thermal_view[charger_regs_pkg::INPUT_IN_RANGE_BIT] =
      state.in_range; // [R14]
  end

  // The timer fault summary is passed through live, not latched.
  always_comb begin
    fault_view = 8'h00; // [R24]
    fault_view[charger_regs_pkg::INPUT_LOW_BIT] =
      state.input_low; // [R15]
    fault_view[charger_regs_pkg::INPUT_OVERVOLTAGE_BIT] =
      state.input_ov; // [R16]
    fault_view[charger_regs_pkg::BATTERY_OVERVOLTAGE_BIT] =
      state.battery_ov; // [R17]
    fault_view[charger_regs_pkg::TIMER_FAULT_SUMMARY_BIT] =
      timer_fault_pending; // [R19]
  end

  // The whole state is registered from one copy.
  always_comb begin
    next_state.option = next_option;
    next_state.temp_flags = next_temp_flags;
    next_state.in_range = next_in_range;
    next_state.input_low = next_input_low;
    next_state.input_ov = next_input_ov;
    next_state.battery_ov = next_battery_ov;
    next_state.rdata = next_rdata;
  end

  // Reset is synchronous and handled in the next-state logic.
  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign reg_rdata = state.rdata;

  // Timer controls.
  assign watchdog_disable =
    state.option[charger_regs_pkg::WATCHDOG_DISABLE_BIT]; // [R1]
  assign charge_timer_disable =
    state.option[charger_regs_pkg::CHARGE_TIMER_DISABLE_BIT]; // [R2]

  // Power path and transceiver supply.
  assign power_path_enable =
    state.option[charger_regs_pkg::POWER_PATH_ENABLE_BIT]; // [R3]
  assign transceiver_supply =
    state.option[charger_regs_pkg::TRANSCEIVER_SUPPLY_BIT]; // [R4]

  // Input current limit controls.
  assign limit_source_pins =
    state.option[charger_regs_pkg::LIMIT_SOURCE_PINS_BIT]; // [R5]
  assign input_limit_enable =
    state.option[charger_regs_pkg::INPUT_LIMIT_ENABLE_BIT]; // [R6]
  assign auto_charge_current_enable =
    state.option[charger_regs_pkg::AUTO_CHARGE_CURRENT_ENABLE_BIT]; // [R7]

  // Summaries and the interrupt follow the latched flags with no delay.
  assign thermal_any = |state.temp_flags | state.in_range; // [R20]
  assign fault_any = state.input_low | state.input_ov |
    state.battery_ov; // [R21]
  assign thermal_summary = thermal_any; // [R20]
  assign fault_summary =
    fault_any | timer_fault_pending | boost_fault_pending; // [R21]
  assign interrupt_active =
    ~interrupt_mask & (thermal_summary | fault_summary); // [R22]

endmodule

// [verilog/charger_regs_pkg.sv]
package charger_regs_pkg;

  // Register offsets.
  localparam logic [7:0] OPTION_ADDR = 8'h02;
  localparam logic [7:0] THERMAL_ADDR = 8'h03;
  localparam logic [7:0] FAULT_ADDR = 8'h04;

  // Option register field positions.
  localparam int WATCHDOG_DISABLE_BIT = 7;
  localparam int CHARGE_TIMER_DISABLE_BIT = 6;
  localparam int POWER_PATH_ENABLE_BIT = 5;
  localparam int TRANSCEIVER_SUPPLY_BIT = 4;
  localparam int LIMIT_SOURCE_PINS_BIT = 2;
  localparam int INPUT_LIMIT_ENABLE_BIT = 1;
  localparam int AUTO_CHARGE_CURRENT_ENABLE_BIT = 0;

  // Option register reset value, writable bits and the bits that
  // survive boost-mode entry.
  localparam logic [7:0] OPTION_RESET = 8'h16;
  localparam logic [7:0] OPTION_WRITABLE = 8'hf7;
  localparam logic [7:0] OPTION_KEEP_ON_BOOST = 8'h10;

  // Thermal status register field positions.
  localparam int TEMP_WARNING_BIT = 5;
  localparam int TEMP_LEVEL_ONE_BIT = 4;
  localparam int TEMP_LEVEL_TWO_BIT = 3;
  localparam int THERMAL_SHUTDOWN_BIT = 2;
  localparam int INPUT_IN_RANGE_BIT = 0;

  // Input fault register field positions.
  localparam int INPUT_LOW_BIT = 4;
  localparam int INPUT_OVERVOLTAGE_BIT = 3;
  localparam int BATTERY_OVERVOLTAGE_BIT = 1;
  localparam int TIMER_FAULT_SUMMARY_BIT = 0;

  // Flag reset value.
  localparam logic [3:0] TEMP_FLAGS_RESET = 4'h0;
  localparam logic FLAG_RESET = 1'b0;

  // Answer to an unmapped address.
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

endpackage
